// file: hw/sbp_mem.sv
// Memory end: two-bank synchronous DRAM column, burst and precharge logic.
// Assumes the controller keeps command spacing and bank-state timing.
`timescale 1ns/100ps
module sbp_mem
  import sbp_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  sbp_if.mem pins,
  output logic [1:0] bank_active
);
  localparam int MEM_AW = 1 + ROW_W + COL_W;

  typedef struct packed {
    logic [1:0] act;
    logic [1:0][ROW_W-1:0] row;
    logic [1:0][RP_W-1:0] pre_cnt;
    logic [1:0] wap_on;
    logic [1:0][1:0] wap_cnt;
    logic [2:0] bl;
    logic bt;
    logic [2:0] cl;
    logic single;
    logic rd_on;
    logic rd_bank;
    logic rd_ap;
    logic [COL_W-1:0] rd_start;
    logic [COL_W-1:0] rd_cnt;
    logic wr_on;
    logic wr_bank;
    logic wr_ap;
    logic [COL_W-1:0] wr_start;
    logic [COL_W-1:0] wr_cnt;
    logic [1:0] pv;
    logic [1:0][MEM_AW-1:0] pa;
    logic [1:0] mq;
    logic [DQ_W-1:0] dout;
    logic [1:0] oe;
  } sbp_mem_s;

  sbp_mem_s s;
  sbp_mem_s next_s;
  logic [DQ_W-1:0] store [0:(1<<MEM_AW)-1];
  logic [3:0] cmd;
  logic bk;
  logic fp;
  logic [COL_W-1:0] m;
  logic iss;
  logic iss_bank;
  logic iss_ap;
  logic [COL_W-1:0] iss_start;
  logic [COL_W-1:0] iss_cnt;
  logic last;
  logic wr_en;
  logic [MEM_AW-1:0] wr_addr;
  logic sel_v;
  logic [MEM_AW-1:0] sel_a;
  logic pre_rd;
  logic pre_wr;

  // Timer widths must hold the precharge and write-recovery counts
  if (RP_CYC >= (1 << RP_W) || WAP_DLY < 1 || WAP_DLY > 3) begin : g_cnt_chk
    $error("Precharge count too wide");
  end

  assign cmd = {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n};
  assign bk = pins.addr[BANK_BIT];
  assign fp = (s.bl == BL_FP);
  assign m = sbp_len_m(s.bl);
  // Precharge cuts a burst in its own bank, or in both banks with AP_BIT set; otherwise the other bank keeps going
  assign pre_rd = cmd == CMD_PRE && (pins.addr[AP_BIT] || bk == s.rd_bank);
  assign pre_wr = cmd == CMD_PRE && (pins.addr[AP_BIT] || bk == s.wr_bank);

  // Next state of banks, bursts and read pipe
  always_comb begin
    next_s = s;
    iss = 1'b0;
    iss_bank = 1'b0;
    iss_ap = 1'b0;
    iss_start = '0;
    iss_cnt = '0;
    last = 1'b0;
    wr_en = 1'b0;
    wr_addr = '0;
    // Precharge timers count down to idle
    for (int b = 0; b < 2; b++) begin
      if (s.pre_cnt[b] != '0) next_s.pre_cnt[b] = s.pre_cnt[b] - 1'b1;
      if (s.wap_on[b]) begin
        if (s.wap_cnt[b] == 2'h1) begin
          next_s.wap_on[b] = 1'b0;
          next_s.act[b] = 1'b0;
          next_s.pre_cnt[b] = RP_W'(RP_CYC);
        end else begin
          next_s.wap_cnt[b] = s.wap_cnt[b] - 2'h1;
        end
      end
    end
    // Row, mode and burst-stop commands
    case (cmd)
      CMD_ACT: begin
        next_s.act[bk] = 1'b1;
        next_s.row[bk] = pins.addr[ROW_W-1:0];
      end
      CMD_PRE: begin
        for (int b = 0; b < 2; b++) begin
          if (pins.addr[AP_BIT] || bk == b[0]) begin
            next_s.act[b] = 1'b0;
            next_s.wap_on[b] = 1'b0;
            next_s.pre_cnt[b] = RP_W'(RP_CYC);
            if (s.rd_bank == b[0]) next_s.rd_on = 1'b0;
            if (s.wr_bank == b[0]) next_s.wr_on = 1'b0;
          end
        end
      end
      CMD_BST: begin
        next_s.rd_on = 1'b0;
        next_s.wr_on = 1'b0;
      end
      CMD_MRS: begin
        next_s.bl = pins.addr[MODE_BL_LSB +: 3];
        next_s.bt = pins.addr[MODE_BT_BIT];
        next_s.cl = pins.addr[MODE_CL_LSB +: 3];
        next_s.single = (pins.addr[MODE_WM_LSB +: 5] == WM_SINGLE);
      end
      default: begin
      end
    endcase
    // Read column issue: new command overrides running burst
    if (cmd == CMD_RD) begin
      iss = 1'b1;
      iss_bank = bk;
      iss_ap = pins.addr[AP_BIT] && !fp;
      iss_start = pins.addr[COL_W-1:0];
      iss_cnt = '0;
      next_s.wr_on = 1'b0;
    end else if (s.rd_on && cmd != CMD_WR && cmd != CMD_BST && !pre_rd) begin
      iss = 1'b1;
      iss_bank = s.rd_bank;
      iss_ap = s.rd_ap;
      iss_start = s.rd_start;
      iss_cnt = s.rd_cnt;
    end
    if (cmd == CMD_WR) next_s.rd_on = 1'b0;
    if (iss) begin
      last = !fp && iss_cnt == m;
      next_s.rd_on = !last;
      next_s.rd_bank = iss_bank;
      next_s.rd_ap = iss_ap;
      next_s.rd_start = iss_start;
      next_s.rd_cnt = iss_cnt + 1'b1;
      if (last && iss_ap) begin
        next_s.act[iss_bank] = 1'b0;
        next_s.pre_cnt[iss_bank] = RP_W'(RP_CYC);
      end
    end
    next_s.pv = {s.pv[0], iss};
    next_s.pa = {s.pa[0], {iss_bank, s.row[iss_bank],
                 sbp_col(iss_start, iss_cnt, s.bl, s.bt)}};
    // Write column issue: data taken in the command clock
    iss = 1'b0;
    if (cmd == CMD_WR) begin
      iss = 1'b1;
      iss_bank = bk;
      iss_ap = pins.addr[AP_BIT] && !fp;
      iss_start = pins.addr[COL_W-1:0];
      iss_cnt = '0;
    end else if (s.wr_on && cmd != CMD_RD && cmd != CMD_BST && !pre_wr) begin
      iss = 1'b1;
      iss_bank = s.wr_bank;
      iss_ap = s.wr_ap;
      iss_start = s.wr_start;
      iss_cnt = s.wr_cnt;
    end
    if (iss) begin
      last = s.single || (!fp && iss_cnt == m);
      wr_en = 1'b1;
      wr_addr = {iss_bank, s.row[iss_bank], sbp_col(iss_start, iss_cnt, s.bl, s.bt)};
      next_s.wr_on = !last;
      next_s.wr_bank = iss_bank;
      next_s.wr_ap = iss_ap;
      next_s.wr_start = iss_start;
      next_s.wr_cnt = iss_cnt + 1'b1;
      if (last && iss_ap) begin
        next_s.wap_on[iss_bank] = 1'b1;
        next_s.wap_cnt[iss_bank] = 2'(WAP_DLY);
      end
    end
    // Output stage: latency minus one, byte masks two clocks
    sel_v = (s.cl == CL_3) ? s.pv[1] : s.pv[0];
    sel_a = (s.cl == CL_3) ? s.pa[1] : s.pa[0];
    next_s.dout = store[sel_a];
    next_s.mq = pins.byte_mask_inputs;
    next_s.oe = {2{sel_v}} & ~s.mq;
  end

  // State register with reset defaults
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
      s.cl <= CL_2;
    end else begin
      s <= next_s;
    end
  end

  // Array write, each byte gated by its mask in the same clock
  always_ff @(posedge aclk) begin
    if (wr_en && !pins.byte_mask_inputs[0]) store[wr_addr][7:0] <= pins.dq[7:0];
    if (wr_en && !pins.byte_mask_inputs[1]) store[wr_addr][15:8] <= pins.dq[15:8];
  end

  assign pins.mem_dq_o = s.dout;
  assign pins.mem_dq_oe_n = ~s.oe;
  assign bank_active = s.act;
endmodule : sbp_mem

// file: common/sbp_pkg.sv
// Shared constants and helpers for the two-bank SDRAM burst core.
// Assumes a single 50 MHz rising-edge clock shared by both ends.
package sbp_pkg;
  localparam int T_CK_NS = 20;
  localparam int T_RP_NS = 20; // Row precharge time, plain default
  localparam int RP_CYC = (T_RP_NS + T_CK_NS - 1) / T_CK_NS < 1 ? 1 :
                          (T_RP_NS + T_CK_NS - 1) / T_CK_NS;
  localparam int RP_W = 4;
  localparam int WAP_DLY = 2; // Clocks from last write word to precharge
  // Pin widths and address fields
  localparam int ADDR_W = 12;
  localparam int ROW_W = 11;
  localparam int COL_W = 8;
  localparam int DQ_W = 16;
  localparam int BANK_BIT = 11;
  localparam int AP_BIT = 10;
  // Commands as {cs_n, ras_n, cas_n, we_n}
  localparam logic [3:0] CMD_MRS = 4'h0;
  localparam logic [3:0] CMD_PRE = 4'h2;
  localparam logic [3:0] CMD_ACT = 4'h3;
  localparam logic [3:0] CMD_WR = 4'h4;
  localparam logic [3:0] CMD_RD = 4'h5;
  localparam logic [3:0] CMD_BST = 4'h6;
  localparam logic [3:0] CMD_NOP = 4'h7;
  // Mode word fields on the address pins
  localparam int MODE_BL_LSB = 0;
  localparam int MODE_BT_BIT = 3;
  localparam int MODE_CL_LSB = 4;
  localparam int MODE_WM_LSB = 7;
  localparam logic [2:0] BL_1 = 3'h0;
  localparam logic [2:0] BL_2 = 3'h1;
  localparam logic [2:0] BL_4 = 3'h2;
  localparam logic [2:0] BL_8 = 3'h3;
  localparam logic [2:0] BL_FP = 3'h7;
  localparam logic [2:0] CL_2 = 3'h2;
  localparam logic [2:0] CL_3 = 3'h3;
  localparam logic [4:0] WM_SINGLE = 5'h04;
  // Controller register map (AXI4-Lite byte addresses)
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_WDATA = 8'h04;
  localparam logic [7:0] REG_CFG = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;
  localparam logic [7:0] REG_RDATA = 8'h10;
  localparam int CMD_ADDR_LSB = 4;
  localparam int CMD_MASK_LSB = 16;
  localparam int CMD_BEATS_LSB = 18;
  localparam int BEATS_W = 9;
  localparam logic [1:0] RESP_OK = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Mask of the wrapping block for a burst-length code
  function automatic logic [COL_W-1:0] sbp_len_m(input logic [2:0] bl);
    case (bl)
      BL_2: return 8'h01;
      BL_4: return 8'h03;
      BL_8: return 8'h07;
      BL_FP: return 8'hFF;
      default: return 8'h00;
    endcase
  endfunction : sbp_len_m

  // Column of beat n from start column s
  function automatic logic [COL_W-1:0] sbp_col(input logic [COL_W-1:0] s,
      input logic [COL_W-1:0] n, input logic [2:0] bl, input logic bt);
    logic [COL_W-1:0] m;
    logic [COL_W-1:0] seq;
    m = sbp_len_m(bl);
    seq = s + n;
    if (bt && bl != BL_FP) return (s & ~m) | ((s ^ n) & m);
    return (s & ~m) | (seq & m);
  endfunction : sbp_col
endpackage : sbp_pkg

// file: common/sbp_if.sv
// Command, mask and data pins between the controller and the memory.
// Resolves the shared data bus from the per-party output enables.
`timescale 1ns/100ps
interface sbp_if;
  logic cs_n;
  logic ras_n;
  logic cas_n;
  logic we_n;
  logic [11:0] addr;
  logic [1:0] byte_mask_inputs;
  logic [15:0] ctl_dq_o;
  logic ctl_dq_oe_n;
  logic [15:0] mem_dq_o;
  logic [1:0] mem_dq_oe_n;
  logic [15:0] dq;

  // Bus level: controller wins, else each memory byte, else low
  assign dq[7:0] = !ctl_dq_oe_n ? ctl_dq_o[7:0] :
                   !mem_dq_oe_n[0] ? mem_dq_o[7:0] : 8'h00;
  assign dq[15:8] = !ctl_dq_oe_n ? ctl_dq_o[15:8] :
                    !mem_dq_oe_n[1] ? mem_dq_o[15:8] : 8'h00;

  modport mem (input cs_n, ras_n, cas_n, we_n, addr, byte_mask_inputs, dq,
               output mem_dq_o, mem_dq_oe_n);
  modport ctl (output cs_n, ras_n, cas_n, we_n, addr, byte_mask_inputs, ctl_dq_o,
               ctl_dq_oe_n, input dq);
endinterface : sbp_if

// file: hw/sbp_ctrl.sv
// Controller end: AXI4-Lite registers that issue raw commands and bursts.
// Assumes software spaces commands and keeps bank timing.
`timescale 1ns/100ps
module sbp_ctrl
  import sbp_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  sbp_if.ctl pins,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  typedef struct packed {
    logic aw_got;
    logic w_got;
    logic [7:0] awaddr;
    logic [31:0] wdat;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [3:0] cmd;
    logic [ADDR_W-1:0] addr;
    logic [1:0] mask;
    logic [DQ_W-1:0] dq_o;
    logic dq_oe;
    logic [BEATS_W-1:0] wbeat;
    logic [1:0] rec;
    logic [1:0] rwait;
    logic [BEATS_W-1:0] rleft;
    logic [7:0] rcount;
    logic [DQ_W-1:0] rlast;
    logic [DQ_W-1:0] wreg;
    logic [1:0] cl;
  } sbp_ctrl_s;

  sbp_ctrl_s s;
  sbp_ctrl_s next_s;
  logic busy;
  logic [BEATS_W-1:0] beats;

  assign busy = s.wbeat != '0 || s.rec != 2'h0 || s.rleft != '0 || s.cmd != CMD_NOP;
  assign beats = s.wdat[CMD_BEATS_LSB +: BEATS_W];

  // Bus slave, command launch, write beats and read capture
  always_comb begin
    next_s = s;
    if (s_axi_awvalid && s_axi_awready) begin
      next_s.aw_got = 1'b1;
      next_s.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_s.w_got = 1'b1;
      next_s.wdat = s_axi_wdata;
      next_s.wstrb = s_axi_wstrb;
    end
    if (s_axi_bvalid && s_axi_bready) next_s.bvalid = 1'b0;
    if (s_axi_rvalid && s_axi_rready) next_s.rvalid = 1'b0;
    // Pins return to no-operation one clock after a command
    next_s.cmd = CMD_NOP;
    if (s.wbeat != '0) begin
      next_s.dq_o = s.dq_o + 1'b1;
      next_s.wbeat = s.wbeat - 1'b1;
      if (s.wbeat == 9'h001) next_s.rec = 2'h2;
    end else begin
      next_s.dq_oe = 1'b0;
      if (s.rec != 2'h0) next_s.rec = s.rec - 2'h1;
    end
    if (s.rwait != 2'h0) begin
      next_s.rwait = s.rwait - 2'h1;
    end else if (s.rleft != '0) begin
      next_s.rleft = s.rleft - 1'b1;
      next_s.rlast = pins.dq;
      next_s.rcount = s.rcount + 8'h01;
    end
    // Register write once address and data are both held
    if (s.aw_got && s.w_got && !s.bvalid) begin
      next_s.aw_got = 1'b0;
      next_s.w_got = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = RESP_OK;
      case (s.awaddr)
        REG_CMD: begin
          if (s.wstrb != 4'h0) begin
            next_s.cmd = s.wdat[3:0];
            next_s.addr = s.wdat[CMD_ADDR_LSB +: ADDR_W];
            next_s.mask = s.wdat[CMD_MASK_LSB +: 2];
            if (s.wdat[3:0] == CMD_WR && beats != '0) begin
              next_s.dq_o = s.wreg;
              next_s.dq_oe = 1'b1;
              next_s.wbeat = beats - 1'b1;
              next_s.rec = (beats == 9'h001) ? 2'h2 : 2'h0;
              next_s.rleft = '0;
            end
            if (s.wdat[3:0] == CMD_RD) begin
              next_s.dq_oe = 1'b0;
              next_s.wbeat = '0;
              next_s.rwait = s.cl;
              next_s.rleft = beats;
            end
          end
        end
        REG_WDATA: next_s.wreg = s.wdat[DQ_W-1:0];
        REG_CFG: next_s.cl = s.wdat[1:0];
        REG_STATUS: next_s.rcount = next_s.rcount - s.rcount; // Keeps a beat caught now
        default: next_s.bresp = RESP_SLVERR;
      endcase
    end
    // Register read, answered one clock after the address
    if (s_axi_arvalid && s_axi_arready) begin
      next_s.rvalid = 1'b1;
      next_s.rresp = RESP_OK;
      case (s_axi_araddr)
        REG_CMD: next_s.rdata = {5'h00, beats, s.mask, s.addr, s.cmd};
        REG_WDATA: next_s.rdata = {16'h0000, s.wreg};
        REG_CFG: next_s.rdata = {30'h0, s.cl};
        REG_STATUS: next_s.rdata = {16'h0000, s.rcount, 7'h00, busy};
        REG_RDATA: next_s.rdata = {16'h0000, s.rlast};
        default: begin
          next_s.rdata = 32'h0;
          next_s.rresp = RESP_SLVERR;
        end
      endcase
    end
  end

  // State register with reset defaults
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
      s.cmd <= CMD_NOP;
      s.cl <= 2'h2;
    end else begin
      s <= next_s;
    end
  end

  assign s_axi_awready = !s.aw_got && !s.bvalid;
  assign s_axi_wready = !s.w_got && !s.bvalid;
  assign s_axi_bvalid = s.bvalid;
  assign s_axi_bresp = s.bresp;
  assign s_axi_arready = !s.rvalid;
  assign s_axi_rvalid = s.rvalid;
  assign s_axi_rdata = s.rdata;
  assign s_axi_rresp = s.rresp;
  assign {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n} = s.cmd;
  assign pins.addr = s.addr;
  assign pins.byte_mask_inputs = s.mask;
  assign pins.ctl_dq_o = s.dq_o;
  assign pins.ctl_dq_oe_n = !s.dq_oe;
endmodule : sbp_ctrl

// file: dv/sbp_checker.sv
// Link checker: read drive, masking and bank-state timing on the pins.
// Assumes it sits beside the interface and also sees the memory's bank flags.
`timescale 1ns/100ps
module sbp_checker
  import sbp_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [11:0] addr,
  input wire logic [1:0] byte_mask_inputs,
  input wire logic [1:0] mem_dq_oe_n,
  input wire logic [1:0] bank_active
);
  logic [3:0] cmd;
  logic [2:0] bl;
  logic [2:0] cl;

  // Command word as seen on the pins
  assign cmd = {cs_n, ras_n, cas_n, we_n};

  // Burst length and latency as last programmed
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bl <= BL_1;
      cl <= CL_2;
    end else if (cmd == CMD_MRS) begin
      bl <= addr[2:0];
      cl <= addr[6:4];
    end
  end

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  AST_RD_CL2:
    assert property (cmd == CMD_RD && cl == CL_2 && byte_mask_inputs == 2'b00
      |-> ##2 mem_dq_oe_n == 2'b00) else $error("no read drive at latency 2");
  AST_RD_CL3:
    assert property (cmd == CMD_RD && cl == CL_3 && byte_mask_inputs == 2'b00
      |-> ##3 mem_dq_oe_n == 2'b00) else $error("no read drive at latency 3");
  AST_BL1_FLOAT:
    assert property (cmd == CMD_RD && cl == CL_2 && bl == BL_1
      |-> ##3 mem_dq_oe_n == 2'b11) else $error("bus held after last word");
  AST_MASK_LO:
    assert property (byte_mask_inputs[0] |-> ##2 mem_dq_oe_n[0])
      else $error("lower byte driven under mask");
  AST_MASK_HI:
    assert property (byte_mask_inputs[1] |-> ##2 mem_dq_oe_n[1])
      else $error("upper byte driven under mask");
  AST_ACT_BANK:
    assert property (cmd == CMD_ACT |=> bank_active[$past(addr[11])])
      else $error("wrong bank activated");
  AST_PRE_ONE:
    assert property (cmd == CMD_PRE && addr[11:10] == 2'b00 && bank_active[1]
      |-> ##2 bank_active == 2'b10) else $error("single precharge wrong");
  AST_PRE_ALL:
    assert property (cmd == CMD_PRE && addr[10] |-> ##2 bank_active == 2'b00)
      else $error("precharge of both banks wrong");
  AST_RD_AP:
    assert property (cmd == CMD_RD && addr[11:10] == 2'b01 && bl == BL_4 && bank_active[0]
      |-> ##1 bank_active[0] [*3] ##1 !bank_active[0]) else $error("read autoprecharge");
  AST_WR_AP:
    assert property (cmd == CMD_WR && addr[11:10] == 2'b01 && bl == BL_1 && bank_active[0]
      |-> ##1 bank_active[0] [*2] ##1 !bank_active[0]) else $error("write autoprecharge");
  AST_FP_NO_AP:
    assert property (cmd == CMD_WR && addr[11:10] == 2'b01 && bl == BL_FP && bank_active[0]
      |-> ##1 bank_active[0] [*4]) else $error("full page autoprecharged");
endmodule : sbp_checker

// file: dv/sdram_burst_precharge_core_tb.sv
// Bench: controller and memory joined on the link, driven over AXI4-Lite.
// Assumes the design ends of hw/ and the shared files of common/.
`timescale 1ns/100ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin error_cnt++; \
  $display("BAD t=%0t got %h exp %h", $time, g, e); end end
module sdram_burst_precharge_core_tb
  import sbp_pkg::*;
;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, bank_active;
  int error_cnt = 0;
  int n_tests = 0;

  // Link and the two ends
  sbp_if bus();
  sbp_mem sbp_mem_inst (.aclk(aclk), .aresetn(aresetn), .pins(bus.mem),
    .bank_active(bank_active));
  sbp_ctrl sbp_ctrl_inst (.aclk(aclk), .aresetn(aresetn), .pins(bus.ctl),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready));
  sbp_checker sbp_checker_inst (.aclk(aclk), .aresetn(aresetn), .cs_n(bus.cs_n),
    .ras_n(bus.ras_n), .cas_n(bus.cas_n), .we_n(bus.we_n), .addr(bus.addr),
    .byte_mask_inputs(bus.byte_mask_inputs), .mem_dq_oe_n(bus.mem_dq_oe_n),
    .bank_active(bank_active));

  // 50 MHz clock
  always #10 aclk = ~aclk;

  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : finish_test

  // One AXI write, address and data offered together
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    r = s_axi_bresp;
  endtask : wr

  // One AXI read
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask : rd

  // Link command, then wait while the controller is busy
  task automatic cmd(input logic [3:0] c, input logic [11:0] ad, input logic [1:0] m,
      input logic [8:0] n);
    logic [1:0] r;
    logic [31:0] s;
    wr(REG_CMD, {5'h00, n, m, ad, c}, r);
    do begin
      rd(REG_STATUS, s, r);
    end while (s[0] !== 1'b0);
  endtask : cmd

  task automatic mode(input logic [2:0] bl, input logic bt, input logic [2:0] cl,
      input logic [4:0] wm);
    logic [1:0] r;
    cmd(CMD_MRS, {wm, cl, bt, bl}, 2'b00, 9'h000);
    wr(REG_CFG, {29'h0, cl}, r);
  endtask : mode

  task automatic wrb(input logic [11:0] ad, input logic [1:0] m, input logic [8:0] n,
      input logic [15:0] d);
    logic [1:0] r;
    wr(REG_WDATA, {16'h0000, d}, r);
    cmd(CMD_WR, ad, m, n);
  endtask : wrb

  // Read n beats; the last captured word and the beat count are judged
  task automatic chk_rd(input logic [11:0] ad, input logic [8:0] n, input logic [1:0] m,
      input logic [15:0] e);
    logic [1:0] r;
    logic [31:0] d;
    wr(REG_STATUS, 32'h0, r);
    cmd(CMD_RD, ad, m, n);
    rd(REG_RDATA, d, r);
    `CHK(d[15:0], e)
    rd(REG_STATUS, d, r);
    `CHK(d[15:8], n[7:0])
  endtask : chk_rd

  task automatic t_reset;
    logic [31:0] d;
    logic [1:0] r;
    `CHK(bus.mem_dq_oe_n, 2'b11)
    rd(REG_CFG, d, r);
    `CHK(d[2:0], CL_2)
    rd(8'h20, d, r);
    `CHK(r, RESP_SLVERR)
    wr(8'h20, 32'h0, r);
    `CHK(r, RESP_SLVERR)
  endtask : t_reset

  // Both orders, lengths 2, 4 and 8 and both latencies from start column 5
  task automatic t_order;
    logic [7:0] mk;
    logic [7:0] c;
    mode(BL_8, 1'b0, CL_2, 5'h00);
    wrb(12'h000, 2'b00, 9'd8, 16'h1100);
    for (int cl = 2; cl <= 3; cl++) begin
      for (int bt = 0; bt < 2; bt++) begin
        for (int b = 1; b <= 3; b++) begin
          mode(b[2:0], bt[0], cl[2:0], 5'h00);
          mk = 8'((1 << b) - 1);
          for (int k = 0; k < (1 << b); k++) begin
            c = bt ? ((8'h05 & ~mk) | ((8'h05 ^ 8'(k)) & mk)) :
                ((8'h05 & ~mk) | ((8'h05 + 8'(k)) & mk));
            chk_rd(12'h005, 9'(k + 1), 2'b00, 16'h1100 + {8'h00, c});
          end
        end
      end
    end
  endtask : t_order

  task automatic t_mask;
    mode(BL_8, 1'b0, CL_2, 5'h00);
    wrb(12'h008, 2'b00, 9'd8, 16'h4400);
    wrb(12'h008, 2'b01, 9'd8, 16'h55F0);
    chk_rd(12'h008, 9'd3, 2'b00, 16'h5502);
    chk_rd(12'h008, 9'd3, 2'b10, 16'h0002);
  endtask : t_mask

  // A second column command cuts a running burst short
  task automatic t_intr;
    logic [1:0] r;
    logic [31:0] d;
    wr(REG_STATUS, 32'h0, r);
    wr(REG_CMD, {5'h00, 9'd8, 2'b00, 12'h000, CMD_RD}, r);
    cmd(CMD_RD, 12'h008, 2'b00, 9'd2);
    rd(REG_RDATA, d, r);
    `CHK(d[15:0], 16'h5501)
    wr(REG_WDATA, 32'h3300, r);
    wr(REG_CMD, {5'h00, 9'd8, 2'b00, 12'h018, CMD_WR}, r);
    cmd(CMD_WR, 12'h020, 2'b00, 9'd2);
    chk_rd(12'h020, 9'd2, 2'b00, 16'h3301);
  endtask : t_intr

  task automatic t_single;
    wrb(12'h010, 2'b00, 9'd8, 16'h7700);
    mode(BL_8, 1'b0, CL_2, WM_SINGLE);
    wrb(12'h010, 2'b00, 9'd8, 16'h6600);
    chk_rd(12'h010, 9'd1, 2'b00, 16'h6600);
    chk_rd(12'h010, 9'd2, 2'b00, 16'h7701);
    chk_rd(12'h010, 9'd8, 2'b00, 16'h7707);
  endtask : t_single

  // Auto-precharge and precharge leave the right banks idle
  task automatic t_bank;
    mode(BL_4, 1'b0, CL_3, 5'h00);
    chk_rd(12'h400, 9'd4, 2'b00, 16'h1103);
    `CHK(bank_active, 2'b10)
    cmd(CMD_ACT, 12'h005, 2'b00, 9'h000);
    `CHK(bank_active, 2'b11)
    cmd(CMD_PRE, 12'h000, 2'b00, 9'h000);
    `CHK(bank_active, 2'b10)
    cmd(CMD_ACT, 12'h005, 2'b00, 9'h000);
    mode(BL_1, 1'b0, CL_2, 5'h00);
    wrb(12'h41E, 2'b00, 9'd1, 16'h9999);
    `CHK(bank_active, 2'b10)
    cmd(CMD_ACT, 12'h005, 2'b00, 9'h000);
    chk_rd(12'h01E, 9'd1, 2'b00, 16'h9999);
    cmd(CMD_PRE, 12'hC00, 2'b00, 9'h000);
    `CHK(bank_active, 2'b00)
    cmd(CMD_ACT, 12'h005, 2'b00, 9'h000);
  endtask : t_bank

  // Full page: wrap past column 255, no interleave, no auto-precharge
  task automatic t_fp;
    mode(BL_FP, 1'b0, CL_2, 5'h00);
    wrb(12'h480, 2'b00, 9'd256, 16'h2000);
    cmd(CMD_BST, 12'h000, 2'b00, 9'h000);
    `CHK(bank_active, 2'b01)
    chk_rd(12'h002, 9'd255, 2'b00, 16'h2080);
    cmd(CMD_BST, 12'h000, 2'b00, 9'h000);
    mode(BL_FP, 1'b1, CL_2, 5'h00);
    chk_rd(12'h002, 9'd3, 2'b00, 16'h2084);
    cmd(CMD_BST, 12'h000, 2'b00, 9'h000);
  endtask : t_fp

  // Main sequence
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset;
    cmd(CMD_ACT, 12'h005, 2'b00, 9'h000);
    cmd(CMD_ACT, 12'h805, 2'b00, 9'h000);
    t_order;
    t_mask;
    t_intr;
    t_single;
    t_bank;
    t_fp;
    finish_test;
  end

  // Watchdog
  initial begin
    #1000000;
    error_cnt++;
    finish_test;
  end
endmodule : sdram_burst_precharge_core_tb
